/* File: common/dac_seq_pkg.sv */
// shared constants and helpers for the dac output mode sequencer
`default_nettype none
package dac_seq_pkg;
    localparam int          SAMPLE_W   = 16;
    localparam int          NUM_CH     = 2;
    // output mode select encodings
    localparam logic [1:0]  MODE_ZOH   = 2'h0;
    localparam logic [1:0]  MODE_RTZ   = 2'h1;
    localparam logic [1:0]  MODE_RF    = 2'h2;
    localparam logic [1:0]  MODE_DES   = 2'h3;
    // dual-edge sub-mode encodings
    localparam logic [1:0]  DES_DIRECT = 2'h0;
    localparam logic [1:0]  DES_LP     = 2'h1;
    localparam logic [1:0]  DES_HP     = 2'h2;
    // input sample formats
    localparam logic [1:0]  FMT_16     = 2'h0;
    localparam logic [1:0]  FMT_12     = 2'h1;
    localparam logic [1:0]  FMT_8      = 2'h2;
    // two's complement zero, reset value of every held sample
    localparam logic [15:0] CODE_ZERO  = 16'h0000;
    localparam logic [15:0] CODE_MAX   = 16'h7FFF;
    localparam logic [15:0] CODE_MIN   = 16'h8000;
    localparam logic [15:0] MSB_FLIP   = 16'h8000;
    // interpolator: taps -1 9 9 -1, gain 16
    localparam int          TAP_CENTER = 9;
    localparam int          TAP_SHIFT  = 4;

    typedef enum logic [3:0] {
        ST_ZOH = 4'b0001,
        ST_RTZ = 4'b0010,
        ST_RF  = 4'b0100,
        ST_DES = 4'b1000
    } mode_t;

    typedef enum logic [2:0] {
        SUB_DIRECT = 3'b001,
        SUB_LP     = 3'b010,
        SUB_HP     = 3'b100
    } sub_t;

    // clamp a wide signed value to the 16-bit code range
    function automatic logic [15:0] sat16(input logic signed [23:0] v);
        if (v > $signed({8'h00, CODE_MAX}))
            return CODE_MAX;
        else if (v < $signed({8'hFF, CODE_MIN}))
            return CODE_MIN;
        else
            return v[15:0];
    endfunction : sat16

    // two's complement to offset binary for the switch array
    function automatic logic [15:0] to_obin(input logic [15:0] c);
        return c ^ MSB_FLIP;
    endfunction : to_obin

    // arithmetic inverse, -32768 saturates to 32767
    function automatic logic [15:0] negate(input logic [15:0] c);
        return sat16(-$signed({{8{c[15]}}, c}));
    endfunction : negate
endpackage : dac_seq_pkg
`default_nettype wire

/* File: src/dac_interp2x.sv */
// 2x interpolator producing rising and falling edge samples
`default_nettype none
module dac_interp2x
    import dac_seq_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [15:0] sample_i,
    input  wire logic        valid_i,
    input  wire logic        highpass_i,
    output logic      [15:0] rise_o,
    output logic      [15:0] fall_o
);
    import dac_seq_pkg::*;

    logic [15:0] hist_q [4];
    logic [15:0] hist_d [4];

    always_comb begin
        hist_d = hist_q;
        if (valid_i) begin
            hist_d[0] = sample_i;
            for (int i = 1; i < 4; i++) begin
                hist_d[i] = hist_q[i-1];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 4; i++) begin
                hist_q[i] <= CODE_ZERO;
            end
        end else begin
            hist_q <= hist_d;
        end
    end

    logic signed [23:0] inner;
    logic signed [23:0] outer;
    logic signed [23:0] acc;
    logic        [15:0] mid;

    always_comb begin
        inner = $signed({{8{hist_q[1][15]}}, hist_q[1]})
              + $signed({{8{hist_q[2][15]}}, hist_q[2]});
        outer = $signed({{8{hist_q[0][15]}}, hist_q[0]})
              + $signed({{8{hist_q[3][15]}}, hist_q[3]});
        acc   = 24'(inner * TAP_CENTER) - outer;
        mid   = sat16(acc >>> TAP_SHIFT);
        rise_o = hist_q[1];
        // high-pass form mixes by (-1)^m at the doubled rate,
        // moving the passband to the upper half of the clock rate
        fall_o = highpass_i ? negate(mid) : mid;
    end
endmodule : dac_interp2x
`default_nettype wire

/* File: src/dac_output_mode_sequencer.sv */
// per-channel output waveform sequencer for a dual 16-bit dac core
//
// Behaviour
// - four output modes: hold, return-to-zero, RF, dual-edge; set by config.
// - hold mode presents each sample at rising edge, unchanged all period.
// - return-to-zero drives sample first half, zero level second half.
// - RF mode drives sample first half, its inverse second half.
// - dual-edge issues distinct samples on rising and falling clock edges.
// - a digital 2x interpolator raises the stream to dual-edge rate.
// - dual-edge has three sub-modes: direct, low-pass, high-pass.
// - direct sub-mode takes two samples per clock; 12/8-bit single channel.
// - low-pass sub-mode interpolates through a low-pass 2x filter.
// - high-pass sub-mode uses a high-pass 2x filter instead.
// - two independent 16-bit channels, each with its own sequencing path.
// - codes are two's complement; offset binary is msb inverted.
// - switch array steers current to positive leg in proportion to code.
`default_nettype none
module dac_output_mode_sequencer
    import dac_seq_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [1:0]  mode_sel_i,
    input  wire logic [1:0]  des_sub_sel_i,
    input  wire logic [1:0]  format_i,
    input  wire logic [15:0] sample_a_i,
    input  wire logic [15:0] sample_a_odd_i,
    input  wire logic        valid_a_i,
    input  wire logic [15:0] sample_b_i,
    input  wire logic [15:0] sample_b_odd_i,
    input  wire logic        valid_b_i,
    output logic      [15:0] steered_current_outputs_a_first_o,
    output logic      [15:0] steered_current_outputs_a_second_o,
    output logic      [15:0] steered_current_outputs_b_first_o,
    output logic      [15:0] steered_current_outputs_b_second_o,
    output logic      [3:0]  mode_active_o,
    output logic      [2:0]  des_sub_active_o,
    output logic             direct_refused_o
);
    import dac_seq_pkg::*;

    // ---------------- mode state ----------------
    mode_t mode_q;
    mode_t mode_d;
    sub_t  sub_q;
    sub_t  sub_d;
    logic  refused_q;
    logic  refused_d;

    // sampled once per clock, so a change never splits a period
    always_comb begin
        case (mode_sel_i)
            MODE_ZOH: mode_d = ST_ZOH;
            MODE_RTZ: mode_d = ST_RTZ;
            MODE_RF:  mode_d = ST_RF;
            MODE_DES: mode_d = ST_DES;
            default:  mode_d = ST_ZOH;
        endcase
        refused_d = 1'b0;
        case (des_sub_sel_i)
            DES_DIRECT: begin
                // direct needs a narrow format; 16-bit falls to low-pass
                if (format_i == FMT_12 || format_i == FMT_8) begin
                    sub_d = SUB_DIRECT;
                end else begin
                    sub_d = SUB_LP;
                    refused_d = 1'b1;
                end
            end
            DES_LP:   sub_d = SUB_LP;
            DES_HP:   sub_d = SUB_HP;
            default:  sub_d = SUB_LP;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q    <= ST_ZOH;
            sub_q     <= SUB_LP;
            refused_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            sub_q     <= sub_d;
            refused_q <= refused_d;
        end
    end

    // ---------------- per-channel sample capture ----------------
    logic [15:0] in_even [NUM_CH];
    logic [15:0] in_odd  [NUM_CH];
    logic        in_vld  [NUM_CH];

    always_comb begin
        in_even[0] = sample_a_i;
        in_odd[0]  = sample_a_odd_i;
        in_vld[0]  = valid_a_i;
        in_even[1] = sample_b_i;
        in_odd[1]  = sample_b_odd_i;
        in_vld[1]  = valid_b_i;
    end

    logic [15:0] held_q  [NUM_CH];
    logic [15:0] held_d  [NUM_CH];
    logic [15:0] heldo_q [NUM_CH];
    logic [15:0] heldo_d [NUM_CH];

    // last valid sample is held; mid-scale until the first arrives
    always_comb begin
        held_d  = held_q;
        heldo_d = heldo_q;
        for (int c = 0; c < NUM_CH; c++) begin
            if (in_vld[c]) begin
                held_d[c]  = in_even[c];
                heldo_d[c] = in_odd[c];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                held_q[c]  <= CODE_ZERO;
                heldo_q[c] <= CODE_ZERO;
            end
        end else begin
            held_q  <= held_d;
            heldo_q <= heldo_d;
        end
    end

    // ---------------- interpolators, one per channel ----------------
    logic [15:0] ip_rise [NUM_CH];
    logic [15:0] ip_fall [NUM_CH];

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        dac_interp2x u_interp (
            .ref_clk_i  (ref_clk_i),
            .reset_n_i  (reset_n_i),
            .sample_i   (in_even[g]),
            .valid_i    (in_vld[g]),
            .highpass_i (sub_q == SUB_HP),
            .rise_o     (ip_rise[g]),
            .fall_o     (ip_fall[g])
        );
    end

    // ---------------- waveform shaping ----------------
    logic [15:0] first_d  [NUM_CH];
    logic [15:0] second_d [NUM_CH];
    logic [15:0] first_q  [NUM_CH];
    logic [15:0] second_q [NUM_CH];

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            first_d[c]  = to_obin(held_q[c]);
            second_d[c] = to_obin(held_q[c]);
            case (mode_q)
                ST_ZOH: begin
                    second_d[c] = to_obin(held_q[c]);
                end
                ST_RTZ: begin
                    second_d[c] = to_obin(CODE_ZERO);
                end
                ST_RF: begin
                    second_d[c] = to_obin(negate(held_q[c]));
                end
                ST_DES: begin
                    case (sub_q)
                        SUB_DIRECT: begin
                            // single channel only: b rests at mid-scale
                            if (c == 0) begin
                                first_d[c]  = to_obin(held_q[c]);
                                second_d[c] = to_obin(heldo_q[c]);
                            end else begin
                                first_d[c]  = to_obin(CODE_ZERO);
                                second_d[c] = to_obin(CODE_ZERO);
                            end
                        end
                        SUB_LP, SUB_HP: begin
                            first_d[c]  = to_obin(ip_rise[c]);
                            second_d[c] = to_obin(ip_fall[c]);
                        end
                        default: begin
                            first_d[c]  = to_obin(CODE_ZERO);
                            second_d[c] = to_obin(CODE_ZERO);
                        end
                    endcase
                end
                default: begin
                    first_d[c]  = to_obin(CODE_ZERO);
                    second_d[c] = to_obin(CODE_ZERO);
                end
            endcase
        end
    end

    // offset binary: all ones steers all switched current to the + leg
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                first_q[c]  <= MSB_FLIP;
                second_q[c] <= MSB_FLIP;
            end
        end else begin
            first_q  <= first_d;
            second_q <= second_d;
        end
    end

    // ---------------- outputs ----------------
    logic [3:0] mode_out_q;
    logic [2:0] sub_out_q;
    logic       refused_out_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_out_q    <= ST_ZOH;
            sub_out_q     <= SUB_LP;
            refused_out_q <= 1'b0;
        end else begin
            mode_out_q    <= mode_q;
            sub_out_q     <= sub_q;
            refused_out_q <= refused_q;
        end
    end

    always_comb begin
        steered_current_outputs_a_first_o  = first_q[0];
        steered_current_outputs_a_second_o = second_q[0];
        steered_current_outputs_b_first_o  = first_q[1];
        steered_current_outputs_b_second_o = second_q[1];
        mode_active_o    = mode_out_q;
        des_sub_active_o = sub_out_q;
        direct_refused_o = refused_out_q;
    end
endmodule : dac_output_mode_sequencer
`default_nettype wire

/* File: verification/switch_array_model.sv */
// behavioural current steering switch array for one output half
`default_nettype none
module switch_array_model (
    input  wire logic [15:0] code_i,
    output logic      [15:0] pos_leg_o,
    output logic      [15:0] neg_leg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // offset binary code is the positive leg share; the rest goes negative
    assign pos_leg_o = code_i;
    assign neg_leg_o = ~code_i;
endmodule : switch_array_model
`default_nettype wire

/* File: verification/dac_seq_properties.sv */
// concurrent checks on the output mode sequencer ports
`default_nettype none
module dac_seq_properties
    import dac_seq_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  mode_sel_i,
    input wire logic [1:0]  des_sub_sel_i,
    input wire logic [1:0]  format_i,
    input wire logic [15:0] sample_a_i,
    input wire logic [15:0] sample_a_odd_i,
    input wire logic        valid_a_i,
    input wire logic [15:0] sample_b_i,
    input wire logic [15:0] sample_b_odd_i,
    input wire logic        valid_b_i,
    input wire logic [15:0] steered_current_outputs_a_first_o,
    input wire logic [15:0] steered_current_outputs_a_second_o,
    input wire logic [15:0] steered_current_outputs_b_first_o,
    input wire logic [15:0] steered_current_outputs_b_second_o,
    input wire logic [3:0]  mode_active_o,
    input wire logic [2:0]  des_sub_active_o,
    input wire logic        direct_refused_o
);
    wire logic [15:0] a1 = steered_current_outputs_a_first_o;
    wire logic [15:0] a2 = steered_current_outputs_a_second_o;
    wire logic [15:0] b1 = steered_current_outputs_b_first_o;
    wire logic [15:0] b2 = steered_current_outputs_b_second_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // inverse taken in offset binary; most negative code saturates
    function automatic logic [15:0] inv_ob(input logic [15:0] c);
        logic [15:0] t;
        t = c ^ 16'h8000;
        t = (t == 16'h8000) ? 16'h7FFF : ~t + 16'h0001;
        return t ^ 16'h8000;
    endfunction : inv_ob
    sequence s_rf_req;
        mode_sel_i == 2'h2;
    endsequence
    sequence s_hp_req;
        mode_sel_i == 2'h3 && des_sub_sel_i == 2'h2;
    endsequence
    sequence s_refuse_req;
        mode_sel_i == 2'h3 && des_sub_sel_i == 2'h0 && format_i == 2'h0;
    endsequence
    AST_RF_REQ: assert property (
        s_rf_req |-> ##2 mode_active_o == 4'b0100)
        else $error("rf mode not active two edges after request");
    AST_ZOH_REQ: assert property (
        mode_sel_i == 2'h0 |-> ##2 mode_active_o == 4'b0001)
        else $error("hold mode not active two edges after request");
    AST_ZOH_HOLD: assert property (
        mode_active_o == 4'b0001 |-> a1 == a2 && b1 == b2)
        else $error("hold mode halves differ");
    AST_RTZ_ZERO: assert property (
        mode_active_o == 4'b0010
        |-> a2 == 16'h8000 && b2 == 16'h8000)
        else $error("rtz second half not at zero level");
    AST_RF_INV: assert property (
        mode_active_o == 4'b0100
        |-> a2 == inv_ob(a1) && b2 == inv_ob(b1))
        else $error("rf second half not the inverse");
    AST_HP_SUB: assert property (
        s_hp_req |-> ##2 des_sub_active_o == 3'b100)
        else $error("high-pass sub-mode not active");
    AST_REFUSE: assert property (
        s_refuse_req
        |-> ##2 direct_refused_o && des_sub_active_o == 3'b010)
        else $error("16-bit direct request not refused to low-pass");
    AST_DIRECT_B: assert property (
        mode_active_o == 4'b1000 && des_sub_active_o == 3'b001
        |-> b1 == 16'h8000 && b2 == 16'h8000)
        else $error("channel b not mid-scale in direct sub-mode");
    AST_ONEHOT: assert property (
        $onehot(mode_active_o) && $onehot(des_sub_active_o))
        else $error("mode or sub-mode state not one-hot");
endmodule : dac_seq_properties
bind dac_output_mode_sequencer dac_seq_properties u_props (.*);
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the output mode sequencer
`default_nettype none
module tb;
    import dac_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, va, vb, refused;
    logic [1:0]  msel, dsel, fmt;
    logic [15:0] sa, sao, sb, sbo, a1, a2, b1, b2, pos, neg, xa, xb;
    logic [15:0] ea, eb;
    logic [3:0]  mact;
    logic [2:0]  sact;
    logic [31:0] seed = 32'h57c43b5e;
    logic [31:0] r;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cyc = 0;
    dac_output_mode_sequencer dut (
        .ref_clk_i(clk), .reset_n_i(rst_n), .mode_sel_i(msel),
        .des_sub_sel_i(dsel), .format_i(fmt), .sample_a_i(sa),
        .sample_a_odd_i(sao), .valid_a_i(va), .sample_b_i(sb),
        .sample_b_odd_i(sbo), .valid_b_i(vb),
        .steered_current_outputs_a_first_o(a1),
        .steered_current_outputs_a_second_o(a2),
        .steered_current_outputs_b_first_o(b1),
        .steered_current_outputs_b_second_o(b2),
        .mode_active_o(mact), .des_sub_active_o(sact),
        .direct_refused_o(refused)
    );
    switch_array_model u_load (
        .code_i(a1), .pos_leg_o(pos), .neg_leg_o(neg)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [15:0] ob(input logic [15:0] x);
        return x ^ 16'h8000;
    endfunction : ob
    function automatic logic [15:0] ng(input logic [15:0] x);
        return (x == 16'h8000) ? 16'h7FFF : ~x + 16'h0001;
    endfunction : ng
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // generous ceiling: the sequence below needs well under 400 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic rst_vals();
        chk(a1, 16'h8000);
        chk(b2, 16'h8000);
        chk({12'h0, mact}, 16'h0001);
        chk({13'h0, sact}, 16'h0002);
        chk({15'h0, refused}, 16'h0000);
    endtask : rst_vals
    // valid stays high with a steady sample so the interpolator settles
    task automatic run(input logic [1:0] m, d, f,
                       input logic [15:0] xo, input int n);
        @(negedge clk);
        {msel, dsel, fmt} = {m, d, f};
        {sa, sao, sb, sbo} = {xa, xo, xb, ~xb};
        {va, vb} = 2'b11;
        repeat (n) @(negedge clk);
    endtask : run
    initial begin
        rst_n = 1'b0;
        {msel, dsel, fmt} = 6'h00;
        {sa, sao, sb, sbo} = 64'h0;
        {va, vb} = 2'b00;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rst_vals();
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            xa = (i < 3) ? 16'h8000 : (i < 6) ? 16'h7FFF : r[15:0];
            xb = r[31:16];
            run(2'(i % 3), 2'h0, 2'h0, 16'h0000, 4);
            chk(a1, ob(xa));
            chk(b1, ob(xb));
            chk(pos, ob(xa));
            chk(neg, ~ob(xa));
            chk({12'h0, mact}, 16'h0001 << (i % 3));
            case (i % 3)
                0: begin
                    chk(a2, ob(xa));
                    chk(b2, ob(xb));
                end
                1: begin
                    chk(a2, 16'h8000);
                    chk(b2, 16'h8000);
                end
                default: begin
                    chk(a2, ob(ng(xa)));
                    chk(b2, ob(ng(xb)));
                end
            endcase
        end
        $display("single edge modes test done");
        for (int s = 0; s < 4; s++) begin
            r = $random(seed);
            xa = r[15:0];
            run(2'h3, 2'(s), 2'h1, r[31:16], 8);
            ea = (s == 2) ? ob(ng(xa)) : ob(xa);
            eb = (s == 2) ? ob(ng(xb)) : ob(xb);
            chk({13'h0, sact}, (s == 3) ? 16'h2 : 16'h1 << s);
            chk({12'h0, mact}, 16'h0008);
            chk(a1, ob(xa));
            if (s == 0) begin
                chk(a2, ob(r[31:16]));
                chk(b1, 16'h8000);
                chk(b2, 16'h8000);
            end else begin
                chk(a2, ea);
                chk(b1, ob(xb));
                chk(b2, eb);
            end
        end
        run(2'h3, 2'h0, 2'h0, 16'h1234, 8);
        chk({15'h0, refused}, 16'h0001);
        chk(a2, ob(xa));
        run(2'h3, 2'h0, 2'h2, 16'h1234, 4);
        chk({15'h0, refused}, 16'h0000);
        chk(a2, ob(16'h1234));
        $display("dual edge test done");
        @(negedge clk);
        rst_n = 1'b0;
        #1;
        rst_vals();
        @(negedge clk);
        rst_n = 1'b1;
        // first edge still shows reset state, second the requested mode
        @(negedge clk);
        chk({12'h0, mact}, 16'h0001);
        chk(a2, 16'h8000);
        @(negedge clk);
        chk({12'h0, mact}, 16'h0008);
        chk(a2, ob(16'h1234));
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
